// [ipc_checker.sv]
// Input bus pattern checker and parity monitor with a Wishbone register slave
// Functional notes
// - Pattern test enabled forces the analog output enable off, ignoring transmit enables.
// - Eight 16-bit key words, one per register, writable at any time.
// - Key word zero aligns to a rising frame or sync strobe, chosen by control.
// - Sequence repeats; after the first mark comparison continues cyclically.
// - Each mismatching bit sets its sticky bit in the 16-bit error location field.
// - Any pattern mismatch sets the summary pattern alarm bit.
// - After reset key word zero holds 0x7A7A.
// - Writing zeros clears error field and alarm; persisting errors set them again.
// - Word parity counts ones over 16 data lanes plus the parity lane.
// - Polarity bit one expects odd, zero even; mismatch raises parity error.
// - Rising and falling edge words flag separate parity alarm bits.
// - Block parity enable makes the frame strobe delimit parity blocks.
// - Frame rise seen at a rising data clock edge closes a block, opens next.
// - Frame level at next falling edge gives block parity, high odd, low even.
// - Block ones count not matching expected parity sets frame parity alarm.
// - Alarm bits stay set until software clears them.
`timescale 1ns/1ns
`default_nettype none

module ipc_checker (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ipc_pkg::IPC_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ipc_pkg::ipc_link_t link_i,
  input wire logic tx_enable_i,
  output logic dac_out_ena_o
);
  import ipc_pkg::*;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wdat,
                                          input logic [3:0] sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = wdat[15:8];
    end
  endfunction : merge16

  function automatic logic key_hit(input logic [IPC_AW-1:0] adr, input int idx);
    key_hit = (adr == IPC_KEY0_OFS + IPC_AW'(4 * idx));
  endfunction : key_hit

  // ****************************************
  // Input synchronisers
  // ****************************************
  ipc_link_t link_s1_r;
  ipc_link_t link_s2_r;
  logic txen_s1_r;
  logic txen_s2_r;
  logic dclk_d_r;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_s1_r <= '0;
      link_s2_r <= '0;
      txen_s1_r <= 1'b0;
      txen_s2_r <= 1'b0;
      dclk_d_r <= 1'b0;
    end else begin
      link_s1_r <= link_i;
      link_s2_r <= link_s1_r;
      txen_s1_r <= tx_enable_i;
      txen_s2_r <= txen_s1_r;
      dclk_d_r <= link_s2_r.dclk;
    end
  end

  logic dclk_rise;
  logic dclk_fall;
  logic dclk_edge;
  assign dclk_rise = link_s2_r.dclk & ~dclk_d_r;
  assign dclk_fall = ~link_s2_r.dclk & dclk_d_r;
  assign dclk_edge = dclk_rise | dclk_fall;

  // ****************************************
  // Registers
  // ****************************************
  logic [IPC_CTRL_W-1:0] ctrl_r;
  logic [15:0] key_r [IPC_KEY_WORDS];
  logic [15:0] result_r;
  logic [IPC_ALM_W-1:0] alarm_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic acc_req;
  logic wr_req;

  assign acc_req = wb_cyc_i & wb_stb_i & ~ack_r;
  // Writes commit at the edge where the master samples ack high
  assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;

  logic test_ena;
  logic wpar_ena;
  logic fpar_ena;
  logic odd_sel;
  logic sync_sel;
  assign test_ena = ctrl_r[IPC_CTRL_TEST_BIT];
  assign wpar_ena = ctrl_r[IPC_CTRL_WPAR_BIT];
  assign fpar_ena = ctrl_r[IPC_CTRL_FPAR_BIT];
  assign odd_sel = ctrl_r[IPC_CTRL_ODD_BIT];
  assign sync_sel = ctrl_r[IPC_CTRL_SYNCSEL_BIT];

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r <= IPC_CTRL_RST;
    end else if (wr_req && wb_adr_i == IPC_CTRL_OFS && wb_sel_i[0]) begin
      ctrl_r <= wb_dat_i[IPC_CTRL_W-1:0];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      key_r[0] <= IPC_KEY0_RST;
      for (int i = 1; i < IPC_KEY_WORDS; i++) begin
        key_r[i] <= IPC_KEY_RST;
      end
    end else begin
      for (int i = 0; i < IPC_KEY_WORDS; i++) begin
        if (wr_req && key_hit(wb_adr_i, i)) begin
          key_r[i] <= merge16(key_r[i], wb_dat_i, wb_sel_i);
        end
      end
    end
  end

  // ****************************************
  // Pattern checker
  // ****************************************
  logic strobe_lvl;
  logic strobe_prev_r;
  logic armed_r;
  logic [2:0] idx_r;
  logic mark;
  logic [2:0] cmp_idx;
  logic cmp_valid;
  logic [15:0] err_vec;

  assign strobe_lvl = sync_sel ? link_s2_r.sync : link_s2_r.frame;
  assign mark = dclk_rise & strobe_lvl & ~strobe_prev_r;
  assign cmp_idx = mark ? 3'h0 : idx_r;
  assign cmp_valid = test_ena & dclk_edge & (armed_r | mark);
  assign err_vec = cmp_valid ? (link_s2_r.data ^ key_r[cmp_idx]) : 16'h0000;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strobe_prev_r <= 1'b0;
    end else if (dclk_rise) begin
      strobe_prev_r <= strobe_lvl;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      armed_r <= 1'b0;
      idx_r <= 3'h0;
    end else if (!test_ena) begin
      armed_r <= 1'b0;
      idx_r <= 3'h0;
    end else if (cmp_valid) begin
      armed_r <= 1'b1;
      idx_r <= cmp_idx + 3'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_r <= IPC_RESULT_RST;
    end else if (wr_req && wb_adr_i == IPC_RESULT_OFS) begin
      result_r <= merge16(result_r, wb_dat_i, wb_sel_i) | err_vec;
    end else begin
      result_r <= result_r | err_vec;
    end
  end

  // ****************************************
  // Word parity
  // ****************************************
  logic word_par_bad;
  logic rpar_err;
  logic fpar_err;
  assign word_par_bad = (^{link_s2_r.data, link_s2_r.parity_lane}) != odd_sel;
  assign rpar_err = wpar_ena & dclk_rise & word_par_bad;
  assign fpar_err = wpar_ena & dclk_fall & word_par_bad;

  // ****************************************
  // Block parity
  // ****************************************
  logic frame_prev_r;
  logic blk_acc_r;
  logic blk_done_r;
  logic blk_pend_r;
  logic boundary;
  logic frame_err;

  assign boundary = fpar_ena & dclk_rise & link_s2_r.frame & ~frame_prev_r;
  assign frame_err = fpar_ena & dclk_fall & blk_pend_r &
                     (link_s2_r.frame != blk_done_r);

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_prev_r <= 1'b0;
    end else if (dclk_rise) begin
      frame_prev_r <= link_s2_r.frame;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      blk_acc_r <= 1'b0;
      blk_done_r <= 1'b0;
      blk_pend_r <= 1'b0;
    end else if (!fpar_ena) begin
      blk_acc_r <= 1'b0;
      blk_pend_r <= 1'b0;
    end else if (boundary) begin
      blk_done_r <= blk_acc_r;
      blk_acc_r <= ^link_s2_r.data;
      blk_pend_r <= 1'b1;
    end else if (dclk_edge) begin
      blk_acc_r <= blk_acc_r ^ (^link_s2_r.data);
      if (dclk_fall) begin
        blk_pend_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Alarm status
  // ****************************************
  logic [IPC_ALM_W-1:0] alm_set;
  always_comb begin
    alm_set = '0;
    alm_set[IPC_ALM_IOTEST_BIT] = |err_vec;
    alm_set[IPC_ALM_RPAR_BIT] = rpar_err;
    alm_set[IPC_ALM_FPAR_BIT] = fpar_err;
    alm_set[IPC_ALM_FRAME_BIT] = frame_err;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      alarm_r <= IPC_ALM_RST;
    end else if (wr_req && wb_adr_i == IPC_ALARM_OFS && wb_sel_i[0]) begin
      alarm_r <= wb_dat_i[IPC_ALM_W-1:0] | alm_set;
    end else begin
      alarm_r <= alarm_r | alm_set;
    end
  end

  // ****************************************
  // Output enable
  // ****************************************
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dac_out_ena_o <= 1'b0;
    end else begin
      dac_out_ena_o <= ~test_ena & (txen_s2_r | ctrl_r[IPC_CTRL_TXEN_BIT]);
    end
  end

  // ****************************************
  // Wishbone answer
  // ****************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (wb_adr_i == IPC_CTRL_OFS) begin
      rd_mux[IPC_CTRL_W-1:0] = ctrl_r;
    end else if (wb_adr_i == IPC_RESULT_OFS) begin
      rd_mux[15:0] = result_r;
    end else if (wb_adr_i == IPC_ALARM_OFS) begin
      rd_mux[IPC_ALM_W-1:0] = alarm_r;
    end else begin
      for (int i = 0; i < IPC_KEY_WORDS; i++) begin
        if (key_hit(wb_adr_i, i)) begin
          rd_mux[15:0] = key_r[i];
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= acc_req;
      rdat_r <= acc_req ? rd_mux : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);

  // The first falling data clock edge after a boundary carries the block parity
  sequence s_block_check;
    fpar_ena && dclk_fall && blk_pend_r;
  endsequence

  AST_TEST_MUTES: assert property (test_ena |=> !dac_out_ena_o)
    else $error("output enabled during pattern test");
  AST_KEY_WRITE: assert property (wr_req && wb_adr_i == IPC_KEY0_OFS
      && wb_sel_i[1:0] == 2'h3 |=> key_r[0] == $past(wb_dat_i[15:0]))
    else $error("key word write lost");
  AST_MARK_ALIGN: assert property (test_ena && mark |=> idx_r == 3'h1)
    else $error("mark did not align to key word zero");
  AST_CYCLIC: assert property (test_ena && armed_r && dclk_edge && !mark
      |=> idx_r == $past(idx_r) + 3'h1)
    else $error("key index did not advance");
  AST_ERR_STICKY: assert property (err_vec != 16'h0000
      |=> (result_r & $past(err_vec)) == $past(err_vec))
    else $error("error location bit not set");
  AST_ALARM_SUMMARY: assert property (err_vec != 16'h0000 |=> alarm_r[IPC_ALM_IOTEST_BIT])
    else $error("pattern alarm not set");
  AST_RPAR: assert property (wpar_ena && dclk_rise && word_par_bad
      |=> alarm_r[IPC_ALM_RPAR_BIT])
    else $error("rising parity alarm missing");
  AST_FPAR: assert property (wpar_ena && dclk_fall && word_par_bad
      |=> alarm_r[IPC_ALM_FPAR_BIT])
    else $error("falling parity alarm missing");
  AST_ALARM_HOLD: assert property (alarm_r[IPC_ALM_FRAME_BIT] && !wr_req
      |=> alarm_r[IPC_ALM_FRAME_BIT])
    else $error("alarm dropped without a write");
  AST_BLOCK_PEND: assert property (boundary |=> blk_pend_r)
    else $error("block parity check not pending");
  AST_BLOCK_ONCE: assert property (s_block_check |=> !blk_pend_r)
    else $error("block parity checked twice");
  AST_FRAME_ALARM: assert property (s_block_check ##0 (link_s2_r.frame != blk_done_r)
      |=> alarm_r[IPC_ALM_FRAME_BIT])
    else $error("frame parity alarm missing");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule : ipc_checker

`default_nettype wire

// [ipc_pkg.sv]
// Constants and types shared by the input bus pattern and parity checker
package ipc_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] IPC_CTRL_OFS = 8'h00;
  localparam logic [7:0] IPC_RESULT_OFS = 8'h04;
  localparam logic [7:0] IPC_ALARM_OFS = 8'h08;
  localparam logic [7:0] IPC_KEY0_OFS = 8'h10;
  localparam int IPC_KEY_WORDS = 8;
  localparam int IPC_AW = 8;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int IPC_CTRL_TEST_BIT = 0;
  localparam int IPC_CTRL_WPAR_BIT = 1;
  localparam int IPC_CTRL_FPAR_BIT = 2;
  localparam int IPC_CTRL_ODD_BIT = 3;
  localparam int IPC_CTRL_SYNCSEL_BIT = 4;
  localparam int IPC_CTRL_TXEN_BIT = 5;
  localparam int IPC_CTRL_W = 6;
  localparam logic [5:0] IPC_CTRL_RST = 6'h00;

  // ****************************************
  // Alarm fields
  // ****************************************
  localparam int IPC_ALM_IOTEST_BIT = 0;
  localparam int IPC_ALM_RPAR_BIT = 1;
  localparam int IPC_ALM_FPAR_BIT = 2;
  localparam int IPC_ALM_FRAME_BIT = 3;
  localparam int IPC_ALM_W = 4;
  localparam logic [3:0] IPC_ALM_RST = 4'h0;

  // ****************************************
  // Data and reset values
  // ****************************************
  localparam int IPC_DW = 16;
  localparam logic [15:0] IPC_KEY0_RST = 16'h7A7A;
  localparam logic [15:0] IPC_KEY_RST = 16'h0000;
  localparam logic [15:0] IPC_RESULT_RST = 16'h0000;

  // Input pins of the LVDS link, all from outside the mclk domain
  typedef struct packed {
    logic dclk;
    logic frame;
    logic sync;
    logic parity_lane;
    logic [15:0] data;
  } ipc_link_t;

endpackage : ipc_pkg

// [ipc_src.sv]
// Source model of the LVDS input bus
`timescale 1ns/1ns
`default_nettype none
module ipc_src (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic sync_sel_i,
  input wire logic blk_i,
  input wire logic blk_bad_i,
  input wire logic par_odd_i,
  input wire logic [1:0] par_bad_i,
  input wire logic [15:0] flip_i,
  input wire logic [127:0] key_i,
  output var ipc_pkg::ipc_link_t link_o,
  output logic wrap_o
);
  import ipc_pkg::*;
  logic [2:0] cnt_r;
  logic [1:0] half_r;
  logic [2:0] idx_r;
  logic first_r;
  logic cur_r;
  logic done_r;
  logic [15:0] w;
  logic [2:0] lim;
  // Halves of 6,6,6,7 cycles average a 125 ns data clock
  assign lim = (half_r == 2'h3) ? 3'h6 : 3'h5;
  assign w = key_i[{idx_r, 4'h0} +: 16] ^ flip_i;
  // ****
  // Words, parity lane and strobes
  // ****
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_o <= '0;
      cnt_r <= 3'h0;
      half_r <= 2'h0;
      idx_r <= 3'h0;
      first_r <= 1'h1;
      cur_r <= 1'h0;
      done_r <= 1'h0;
      wrap_o <= 1'h0;
    end else if (!run_i) begin
      // Clock stands still, released lanes keep toggling
      link_o <= {3'h0, ~link_o.parity_lane, ~link_o.data};
      cnt_r <= 3'h0;
      half_r <= 2'h0;
      idx_r <= 3'h0;
      first_r <= 1'h1;
      wrap_o <= 1'h0;
    end else begin
      wrap_o <= 1'h0;
      cnt_r <= (cnt_r == lim) ? 3'h0 : cnt_r + 3'h1;
      if (cnt_r == lim) begin
        link_o.dclk <= ~link_o.dclk;
        half_r <= half_r + 2'h1;
      end
      // Words change mid-half so they are stable around each edge
      if (cnt_r == 3'h2) begin
        link_o.data <= w;
        link_o.parity_lane <= ^w ^ par_odd_i ^ par_bad_i[link_o.dclk];
        idx_r <= idx_r + 3'h1;
        wrap_o <= (idx_r == 3'h7);
        first_r <= first_r & (idx_r != 3'h7);
        cur_r <= (idx_r == 3'h0) ? ^w : cur_r ^ (^w);
        done_r <= (idx_r == 3'h0) ? cur_r : done_r;
        if (blk_i) begin
          // Eight-word blocks stay aligned with the sequence frames
          link_o.frame <= (idx_r == 3'h0) | ((idx_r == 3'h1) & (done_r ^ blk_bad_i));
          link_o.sync <= 1'h0;
        end else begin
          // The other strobe rises mid-sequence as a decoy
          link_o.frame <= first_r & (idx_r == (sync_sel_i ? 3'h4 : 3'h0));
          link_o.sync <= first_r & (idx_r == (sync_sel_i ? 3'h0 : 3'h4));
        end
      end
    end
  end
endmodule : ipc_src
`default_nettype wire

// [ipc_tb.sv]
// Self-checking bench of the pattern and parity checker
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ipc_pkg::*;
  logic mclk, nrst, cyc, stb, we, ack, txen, ena, run, ssel, blk, bbad, podd, wrap;
  logic [1:0] pbad;
  logic [3:0] sel;
  logic [7:0] adr;
  logic [15:0] flip;
  logic [31:0] wdat, rdat, got;
  logic [127:0] keys;
  ipc_link_t link;
  int err_total, n_checks;
  ipc_checker dut (.mclk_i(mclk), .nrst_i(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .link_i(link), .tx_enable_i(txen), .dac_out_ena_o(ena));
  ipc_src src (.mclk_i(mclk), .nrst_i(nrst), .run_i(run), .sync_sel_i(ssel), .blk_i(blk),
    .blk_bad_i(bbad), .par_odd_i(podd), .par_bad_i(pbad), .flip_i(flip), .key_i(keys),
    .link_o(link), .wrap_o(wrap));
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // ****
  // Bus and compare helpers
  // ****
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge mclk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    chk("bus ack", 32'h1, {31'h0, ack});
    got = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask : bus
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    bus(1'h0, a, 16'h0000);
    chk($sformatf("reg %h", a), {16'h0000, e}, got);
  endtask : rc
  task automatic clr;
    bus(1'h1, IPC_RESULT_OFS, 16'h0000);
    bus(1'h1, IPC_ALARM_OFS, 16'h0000);
  endtask : clr
  task automatic seqs(input int n);
    int t;
    repeat (n) begin
      t = 0;
      do begin
        @(posedge mclk);
        t++;
      end while (wrap !== 1'h1 && t < 200);
      chk("link wrap", 32'h1, {31'h0, wrap});
    end
  endtask : seqs
  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    rc(IPC_KEY0_OFS, IPC_KEY0_RST);
    rc(IPC_CTRL_OFS, IPC_CTRL_RST);
    rc(IPC_RESULT_OFS, IPC_RESULT_RST);
    rc(IPC_ALARM_OFS, IPC_ALM_RST);
    bus(1'h1, 8'h30, 16'hFFFF);
    rc(8'h30, 16'h0000);
    for (int k = 0; k < IPC_KEY_WORDS; k++) begin
      bus(1'h1, IPC_KEY0_OFS + 8'(4 * k), keys[16*k +: 16]);
      rc(IPC_KEY0_OFS + 8'(4 * k), keys[16*k +: 16]);
    end
    $display("register test done");
  endtask : t_regs
  task automatic t_ena;
    txen <= 1'h0;
    repeat (5) @(posedge mclk);
    chk("out ena", 32'h0, {31'h0, ena});
    bus(1'h1, IPC_CTRL_OFS, 16'h0020);
    repeat (4) @(posedge mclk);
    chk("out ena", 32'h1, {31'h0, ena});
    bus(1'h1, IPC_CTRL_OFS, 16'h0021);
    repeat (4) @(posedge mclk);
    chk("out ena", 32'h0, {31'h0, ena});
    bus(1'h1, IPC_CTRL_OFS, 16'h0000);
    txen <= 1'h1;
    repeat (5) @(posedge mclk);
    chk("out ena", 32'h1, {31'h0, ena});
    $display("output enable test done");
  endtask : t_ena
  task automatic t_pat(input logic s);
    ssel <= s;
    bus(1'h1, IPC_CTRL_OFS, {11'h000, s, 4'h1});
    run <= 1'h1;
    seqs(100);
    chk("out ena", 32'h0, {31'h0, ena});
    clr;
    seqs(4);
    rc(IPC_RESULT_OFS, 16'h0000);
    rc(IPC_ALARM_OFS, 16'h0000);
    flip <= 16'h0001;
    seqs(2);
    rc(IPC_RESULT_OFS, 16'h0001);
    rc(IPC_ALARM_OFS, 16'h0001);
    clr;
    seqs(2);
    rc(IPC_RESULT_OFS, 16'h0001);
    flip <= 16'h0000;
    seqs(2);
    clr;
    seqs(2);
    rc(IPC_RESULT_OFS, 16'h0000);
    rc(IPC_ALARM_OFS, 16'h0000);
    run <= 1'h0;
    bus(1'h1, IPC_CTRL_OFS, 16'h0000);
    $display("pattern test done");
  endtask : t_pat
  task automatic t_wpar(input logic odd);
    podd <= odd;
    bus(1'h1, IPC_CTRL_OFS, {12'h000, odd, 3'h2});
    run <= 1'h1;
    seqs(2);
    clr;
    seqs(2);
    rc(IPC_ALARM_OFS, 16'h0000);
    pbad <= 2'h1;
    seqs(2);
    rc(IPC_ALARM_OFS, 16'h0002);
    pbad <= 2'h2;
    seqs(1);
    clr;
    seqs(2);
    rc(IPC_ALARM_OFS, 16'h0004);
    pbad <= 2'h0;
    run <= 1'h0;
    $display("word parity test done");
  endtask : t_wpar
  task automatic t_blk;
    blk <= 1'h1;
    bus(1'h1, IPC_CTRL_OFS, 16'h0004);
    run <= 1'h1;
    seqs(3);
    clr;
    seqs(3);
    rc(IPC_ALARM_OFS, 16'h0000);
    bbad <= 1'h1;
    seqs(3);
    rc(IPC_ALARM_OFS, 16'h0008);
    bbad <= 1'h0;
    seqs(3);
    rc(IPC_ALARM_OFS, 16'h0008);
    clr;
    seqs(3);
    rc(IPC_ALARM_OFS, 16'h0000);
    run <= 1'h0;
    $display("block parity test done");
  endtask : t_blk
  initial begin
    {nrst, cyc, stb, we, run, ssel, blk, bbad, podd} <= 9'h000;
    {txen, pbad, sel, adr, wdat, flip} <= {1'h1, 2'h0, 4'h3, 8'h00, 32'h0, 16'h0};
    err_total = 0;
    n_checks = 0;
    keys <= {16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0008, 16'h0004, 16'h0003, 16'h7A7A};
    repeat (2) @(posedge mclk);
    nrst <= 1'h1;
    t_regs;
    t_ena;
    t_pat(1'h0);
    t_pat(1'h1);
    t_wpar(1'h0);
    t_wpar(1'h1);
    t_blk;
    conclude;
  end
  initial begin
    #400000;
    $display("MISMATCH watchdog expected done seen hang");
    err_total++;
    conclude;
  end
endmodule : testbench
`default_nettype wire
